// >>> src/dtpfs_pin_mux.sv
// pin function select for the debug, trace, interrupt, timer and analog pin group
// assumes pins are synchronous to clk; the debug port core decodes the
// serial-wire switch sequence and reports it as one-cycle requests.
`timescale 1ns/1ns
`include "dtpfs_regs.svh"

module dtpfs_pin_mux (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic system_reset_n,
  input wire logic swd_switch_req,
  input wire logic jtag_switch_req,
  input wire logic [7:0] debug_pin_config,
  input wire logic [15:0] port_c_low_config,
  input wire logic [15:0] port_b_low_config,
  input wire logic [15:0] port_b_high_config,
  input wire logic trace_enable,
  input wire logic trace_async_sel,
  input wire dtpfs_pkg::dtpfs_trace_width_e trace_width,
  input wire logic trace_async_data,
  input wire logic sync_trace_clock,
  input wire logic sync_trace_bit_zero,
  input wire logic sync_trace_bit_one,
  input wire logic timer_one_ch2_out_en,
  input wire logic timer_one_channel_two,
  input wire logic ref_output_enable,
  input wire logic swd_dio_out,
  input wire logic swd_dio_oe,
  input wire logic [5:0] gpio_out,
  input wire logic [5:0] gpio_oe,
  input wire logic [5:0] pin_in,
  input wire logic [23:0] other_pin_in,
  input wire logic [4:0] interrupt_c_pin_select,
  input wire logic [4:0] interrupt_d_pin_select,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe,
  output logic [5:0] pin_pullup,
  output logic [5:0] pin_analog,
  output logic vref_drive,
  output logic debug_mode_swd,
  output logic debug_test_data_in,
  output logic debug_test_mode_select,
  output logic swd_dio_in,
  output logic debug_test_reset_n,
  output logic ext_interrupt_a,
  output logic ext_interrupt_c,
  output logic ext_interrupt_d,
  output logic timer_one_channel_two_in,
  output logic timer_one_ext_clock,
  output logic timer_two_clock_mask,
  output logic [5:0] gpio_in
);
  import dtpfs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic dtpfs_pin_mode_e pin_mode(input logic [3:0] field);
    if (field == `DTPFS_ENC_ANALOG)
    begin
      pin_mode = DTPFS_PM_ANALOG;
    end
    else if (field == `DTPFS_ENC_ALT_OUT)
    begin
      pin_mode = DTPFS_PM_ALT;
    end
    else if (field == `DTPFS_ENC_ALT_OD)
    begin
      pin_mode = DTPFS_PM_ALT_OD;
    end
    else
    begin
      pin_mode = DTPFS_PM_GPIO;
    end
  endfunction

  // returns {out, oe}; open-drain only ever pulls low
  function automatic logic [1:0] pad_drive(input dtpfs_pin_mode_e m, input logic alt_ok,
                                           input logic alt_val, input logic g_o, input logic g_oe);
    case (m)
      DTPFS_PM_ALT:    pad_drive = {alt_val & alt_ok, alt_ok};
      DTPFS_PM_ALT_OD: pad_drive = {1'b0, alt_ok & ~alt_val};
      DTPFS_PM_GPIO:   pad_drive = {g_o, g_oe};
      default:         pad_drive = 2'b00;
    endcase
  endfunction

  function automatic logic route_irq(input logic [4:0] sel, input logic [23:0] pins,
                                     input logic dflt);
    if (sel < 5'(`DTPFS_NUM_GPIO))
    begin
      route_irq = pins[sel];
    end
    else
    begin
      route_irq = dflt;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // debug port mode

  dtpfs_dbg_mode_e mode_ff;
  dtpfs_dbg_mode_e nxt_mode;

  always_comb
  begin
    nxt_mode = mode_ff;
    if (!system_reset_n)
    begin
      nxt_mode = DTPFS_DBG_JTAG;
    end
    else
    begin
      case (mode_ff)
        DTPFS_DBG_JTAG: if (swd_switch_req) nxt_mode = DTPFS_DBG_SWD;
        DTPFS_DBG_SWD:  if (jtag_switch_req) nxt_mode = DTPFS_DBG_JTAG;
        default:        nxt_mode = DTPFS_DBG_JTAG;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_ff <= DTPFS_DBG_JTAG;
    end
    else
    begin
      mode_ff <= nxt_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin decode

  logic released;
  logic is_swd;
  logic is_jtag;
  dtpfs_pin_mode_e m_c1;
  dtpfs_pin_mode_e m_c0;
  dtpfs_pin_mode_e m_b0;
  dtpfs_pin_mode_e m_b7;
  logic trace1_on;
  logic swo_sel;
  logic trace0_sel;
  logic debug_test_reset_on;
  logic [5:0] nxt_out;
  logic [5:0] nxt_oe;
  logic [5:0] nxt_pu;
  logic [5:0] nxt_an;
  logic [1:0] drv;

  assign m_c1 = pin_mode(port_c_low_config[`DTPFS_PC1_FIELD_LSB +: 4]);
  assign m_c0 = pin_mode(port_c_low_config[`DTPFS_PC0_FIELD_LSB +: 4]);
  assign m_b0 = pin_mode(port_b_low_config[`DTPFS_PB0_FIELD_LSB +: 4]);
  assign m_b7 = pin_mode(port_b_high_config[`DTPFS_PB7_FIELD_LSB +: 4]);

  assign released = debug_pin_config[`DTPFS_DBG_RELEASE_BIT];
  assign is_swd = (mode_ff == DTPFS_DBG_SWD);
  assign is_jtag = (mode_ff == DTPFS_DBG_JTAG);
  // trace bit one needs two or four wires
  assign trace1_on = trace_enable && (m_c0 == DTPFS_PM_ALT || m_c0 == DTPFS_PM_ALT_OD)
                     && (trace_width == DTPFS_TW_TWO || trace_width == DTPFS_TW_FOUR);
  assign swo_sel = trace_enable && trace_async_sel;
  assign trace0_sel = trace_enable && !trace_async_sel && (trace_width != DTPFS_TW_NONE);
  // test reset only in jtag without trace bit one
  assign debug_test_reset_on = is_jtag && !released && !trace1_on;

  always_comb
  begin
    nxt_out = 6'h00;
    nxt_oe = 6'h00;
    nxt_pu = 6'h00;
    nxt_an = 6'h00;
    drv = 2'b00;

    if (released || is_swd)
    begin
      nxt_out[`DTPFS_IDX_C3] = gpio_out[`DTPFS_IDX_C3];
      nxt_oe[`DTPFS_IDX_C3] = gpio_oe[`DTPFS_IDX_C3];
    end
    else
    begin
      nxt_pu[`DTPFS_IDX_C3] = 1'b1;
    end

    if (released)
    begin
      nxt_out[`DTPFS_IDX_C4] = gpio_out[`DTPFS_IDX_C4];
      nxt_oe[`DTPFS_IDX_C4] = gpio_oe[`DTPFS_IDX_C4];
    end
    else
    begin
      nxt_pu[`DTPFS_IDX_C4] = 1'b1;
      if (is_swd)
      begin
        nxt_out[`DTPFS_IDX_C4] = swd_dio_out;
        nxt_oe[`DTPFS_IDX_C4] = swd_dio_oe;
      end
    end

    drv = pad_drive(m_b0, trace_enable, sync_trace_clock, gpio_out[`DTPFS_IDX_B0],
                    gpio_oe[`DTPFS_IDX_B0]);
    nxt_out[`DTPFS_IDX_B0] = drv[1];
    nxt_oe[`DTPFS_IDX_B0] = drv[0];
    nxt_an[`DTPFS_IDX_B0] = (m_b0 == DTPFS_PM_ANALOG);

    // async trace or trace bit zero
    drv = pad_drive(m_c1, swo_sel || trace0_sel,
                    swo_sel ? trace_async_data : sync_trace_bit_zero,
                    gpio_out[`DTPFS_IDX_C1], gpio_oe[`DTPFS_IDX_C1]);
    nxt_out[`DTPFS_IDX_C1] = drv[1];
    nxt_oe[`DTPFS_IDX_C1] = drv[0];
    nxt_an[`DTPFS_IDX_C1] = (m_c1 == DTPFS_PM_ANALOG);

    // test reset pin: trace, debug input, or gpio
    if (trace1_on)
    begin
      drv = pad_drive(m_c0, 1'b1, sync_trace_bit_one, 1'b0, 1'b0);
      nxt_out[`DTPFS_IDX_C0] = drv[1];
      nxt_oe[`DTPFS_IDX_C0] = drv[0];
    end
    else if (debug_test_reset_on)
    begin
      nxt_pu[`DTPFS_IDX_C0] = 1'b1;
    end
    else
    begin
      nxt_out[`DTPFS_IDX_C0] = gpio_out[`DTPFS_IDX_C0];
      nxt_oe[`DTPFS_IDX_C0] = gpio_oe[`DTPFS_IDX_C0];
    end

    drv = pad_drive(m_b7, timer_one_ch2_out_en, timer_one_channel_two,
                    gpio_out[`DTPFS_IDX_B7], gpio_oe[`DTPFS_IDX_B7]);
    nxt_out[`DTPFS_IDX_B7] = drv[1];
    nxt_oe[`DTPFS_IDX_B7] = drv[0];
    nxt_an[`DTPFS_IDX_B7] = (m_b7 == DTPFS_PM_ANALOG);
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad registers

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_out <= `DTPFS_RST_PINS;
      pin_oe <= `DTPFS_RST_PINS;
      pin_pullup <= `DTPFS_RST_PINS;
      pin_analog <= `DTPFS_RST_PINS;
      vref_drive <= 1'b0;
    end
    else
    begin
      pin_out <= nxt_out;
      pin_oe <= nxt_oe;
      pin_pullup <= nxt_pu;
      pin_analog <= nxt_an;
      vref_drive <= (m_b0 == DTPFS_PM_ANALOG) && ref_output_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // inward signals

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      debug_mode_swd <= 1'b0;
      debug_test_data_in <= 1'b0;
      debug_test_mode_select <= 1'b0;
      swd_dio_in <= 1'b0;
      debug_test_reset_n <= `DTPFS_RST_DEBUG_TEST_RESET_N;
      gpio_in <= `DTPFS_RST_PINS;
    end
    else
    begin
      debug_mode_swd <= (nxt_mode == DTPFS_DBG_SWD);
      debug_test_data_in <= pin_in[`DTPFS_IDX_C3];
      debug_test_mode_select <= pin_in[`DTPFS_IDX_C4];
      swd_dio_in <= pin_in[`DTPFS_IDX_C4];
      // reset held inactive when not taken
      debug_test_reset_n <= debug_test_reset_on ? pin_in[`DTPFS_IDX_C0] : 1'b1;
      gpio_in <= pin_in;
    end
  end

  // inputs stay connected whatever the output function, as on a schmitt pad
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_interrupt_a <= `DTPFS_RST_IRQ;
      ext_interrupt_c <= `DTPFS_RST_IRQ;
      ext_interrupt_d <= `DTPFS_RST_IRQ;
      timer_one_channel_two_in <= 1'b0;
      timer_one_ext_clock <= 1'b0;
      timer_two_clock_mask <= 1'b0;
    end
    else
    begin
      ext_interrupt_a <= pin_in[`DTPFS_IDX_B0];
      ext_interrupt_c <= route_irq(interrupt_c_pin_select, other_pin_in, pin_in[`DTPFS_IDX_B7]);
      ext_interrupt_d <= route_irq(interrupt_d_pin_select, other_pin_in, pin_in[`DTPFS_IDX_C0]);
      timer_one_channel_two_in <= pin_in[`DTPFS_IDX_B7];
      timer_one_ext_clock <= pin_in[`DTPFS_IDX_B0];
      timer_two_clock_mask <= pin_in[`DTPFS_IDX_B0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_sysreset_to_jtag:
    assert property (@(posedge clk) disable iff (!rst_b)
      !system_reset_n |=> !debug_mode_swd && is_jtag)
    else $error("debug mode not jtag after system reset");

  a_swdio_drive:
    assert property (@(posedge clk) disable iff (!rst_b)
      is_swd && !released |=> pin_oe[`DTPFS_IDX_C4] == $past(swd_dio_oe))
    else $error("serial-wire data enable not passed to pin");

  a_tms_gpio_held:
    assert property (@(posedge clk) disable iff (!rst_b)
      !released && is_jtag |=> !pin_oe[`DTPFS_IDX_C4] && pin_pullup[`DTPFS_IDX_C4])
    else $error("mode-select pin driven while debug owns it");

  a_tdi_release:
    assert property (@(posedge clk) disable iff (!rst_b)
      released || is_swd |=> pin_oe[`DTPFS_IDX_C3] == $past(gpio_oe[`DTPFS_IDX_C3]))
    else $error("data-in pin not released to gpio");

  a_debug_test_reset_gate:
    assert property (@(posedge clk) disable iff (!rst_b)
      !is_jtag || trace1_on |=> debug_test_reset_n)
    else $error("test reset taken outside jtag");

  a_pullup_tdi:
    assert property (@(posedge clk) disable iff (!rst_b)
      pin_pullup[`DTPFS_IDX_C3] |-> $past(is_jtag) && !$past(released))
    else $error("data-in pull-up outside debug use");

  a_trace_one_out:
    assert property (@(posedge clk) disable iff (!rst_b)
      trace1_on && m_c0 == DTPFS_PM_ALT |=> pin_oe[`DTPFS_IDX_C0]
        && pin_out[`DTPFS_IDX_C0] == $past(sync_trace_bit_one))
    else $error("trace bit one not on pin");

  a_trace_clk_off:
    assert property (@(posedge clk) disable iff (!rst_b)
      !trace_enable && m_b0 == DTPFS_PM_ALT |=> !pin_oe[`DTPFS_IDX_B0])
    else $error("trace clock driven while trace off");

  a_timer_out_gate:
    assert property (@(posedge clk) disable iff (!rst_b)
      m_b7 == DTPFS_PM_ALT ##1 pin_oe[`DTPFS_IDX_B7] |-> $past(timer_one_ch2_out_en))
    else $error("timer output driven without enable");

  a_analog_excl:
    assert property (@(posedge clk) disable iff (!rst_b)
      pin_analog[`DTPFS_IDX_B7] |-> !pin_oe[`DTPFS_IDX_B7])
    else $error("analog pin also driven digitally");

  a_vref_gate:
    assert property (@(posedge clk) disable iff (!rst_b)
      vref_drive |-> pin_analog[`DTPFS_IDX_B0] && $past(ref_output_enable))
    else $error("reference driven without enable");

endmodule // dtpfs_pin_mux

// >>> src/dtpfs_regs.svh
// constants for the debug/trace pin function select block
// assumes the per-pin configuration words are held elsewhere and arrive as plain ports
`ifndef DTPFS_REGS_SVH
`define DTPFS_REGS_SVH

// bit of the debug configuration word that releases debug pins to gpio
`define DTPFS_DBG_RELEASE_BIT 5
// low bit of each pin's 4-bit field in its configuration word
`define DTPFS_PC1_FIELD_LSB 4
`define DTPFS_PC0_FIELD_LSB 0
`define DTPFS_PB0_FIELD_LSB 0
`define DTPFS_PB7_FIELD_LSB 12
// field encodings
`define DTPFS_ENC_ANALOG 4'h0
`define DTPFS_ENC_ALT_OUT 4'h9
`define DTPFS_ENC_ALT_OD 4'hD
// pin slots in the six-pin vectors
`define DTPFS_IDX_C3 0
`define DTPFS_IDX_C4 1
`define DTPFS_IDX_B0 2
`define DTPFS_IDX_C1 3
`define DTPFS_IDX_C0 4
`define DTPFS_IDX_B7 5
`define DTPFS_NUM_PINS 6
// interrupt routing: other digital pins and the default selector value
`define DTPFS_NUM_GPIO 24
`define DTPFS_IRQ_SEL_DEFAULT 5'h1F
// reset values
`define DTPFS_RST_PINS 6'h00
`define DTPFS_RST_IRQ 1'h0
`define DTPFS_RST_DEBUG_TEST_RESET_N 1'h1

`endif

// >>> src/dtpfs_pkg.sv
// types for the debug/trace pin function select block
// assumes dtpfs_regs.svh supplies the numeric constants
package dtpfs_pkg;

  typedef enum logic [3:0] {
    DTPFS_PM_GPIO = 4'h1,
    DTPFS_PM_ALT = 4'h2,
    DTPFS_PM_ALT_OD = 4'h4,
    DTPFS_PM_ANALOG = 4'h8
  } dtpfs_pin_mode_e;

  typedef enum logic [1:0] {
    DTPFS_DBG_JTAG = 2'h1,
    DTPFS_DBG_SWD = 2'h2
  } dtpfs_dbg_mode_e;

  typedef enum logic [1:0] {
    DTPFS_TW_NONE = 2'h0,
    DTPFS_TW_ONE = 2'h1,
    DTPFS_TW_TWO = 2'h2,
    DTPFS_TW_FOUR = 2'h3
  } dtpfs_trace_width_e;

endpackage

// >>> verification/dtpfs_board.sv
// board model: debugger drive, pad pull-ups and floating pads
// assumes the bench sets the debugger's drive per pin slot
`timescale 1ns/1ns

module dtpfs_board (
  input wire logic clk,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] pin_pullup,
  input wire logic [5:0] dbg_oe,
  input wire logic [5:0] dbg_val,
  output logic [5:0] pin_in
);
  // an undriven pad without pull-up toggles, so a stale level never reads as a driven one
  logic [5:0] float_ff = 6'h2A;

  always_ff @(posedge clk)
  begin
    float_ff <= ~float_ff;
  end

  ////////////////////////////////////////////////////////////
  // pad resolution
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (dbg_oe[i])
        pin_in[i] = dbg_val[i];
      else
        pin_in[i] = pin_pullup[i] | float_ff[i];
    end
  end
endmodule // dtpfs_board

// >>> verification/dtpfs_pin_mux_bench.sv
// self-checking bench for the debug/trace pin function select block
// assumes dtpfs_board resolves the pads; field codes 1 gpio, 9 alt, D open-drain, 0 analog
`timescale 1ns/1ns

module dtpfs_pin_mux_bench;
  import dtpfs_pkg::*;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic system_reset_n = 1'h1, swd_switch_req = 1'h0, jtag_switch_req = 1'h0;
  logic [7:0] debug_pin_config = 8'h00;
  logic [15:0] port_c_low_config = 16'h1111, port_b_low_config = 16'h1111, port_b_high_config = 16'h1111;
  logic trace_enable = 1'h0, trace_async_sel = 1'h0, trace_async_data = 1'h0, sync_trace_clock = 1'h0;
  logic sync_trace_bit_zero = 1'h0, sync_trace_bit_one = 1'h0, timer_one_ch2_out_en = 1'h0;
  logic timer_one_channel_two = 1'h0, ref_output_enable = 1'h0, swd_dio_out = 1'h0, swd_dio_oe = 1'h0;
  dtpfs_trace_width_e trace_width = DTPFS_TW_NONE;
  logic [5:0] gpio_out = 6'h00, gpio_oe = 6'h00, dbg_oe = 6'h00, dbg_val = 6'h00;
  logic [23:0] other_pin_in = 24'h000000;
  logic [4:0] interrupt_c_pin_select = 5'h1F, interrupt_d_pin_select = 5'h1F;
  logic [5:0] pin_in, pin_out, pin_oe, pin_pullup, pin_analog, gpio_in;
  logic vref_drive, debug_mode_swd, debug_test_data_in, debug_test_mode_select, swd_dio_in, debug_test_reset_n;
  logic ext_interrupt_a, ext_interrupt_c, ext_interrupt_d, timer_one_channel_two_in;
  logic timer_one_ext_clock, timer_two_clock_mask;
  int miscompares = 0;
  int checked = 0;

  always #5 clk = ~clk;

  dtpfs_pin_mux dut (.clk, .rst_b, .system_reset_n, .swd_switch_req, .jtag_switch_req, .debug_pin_config,
    .port_c_low_config, .port_b_low_config, .port_b_high_config, .trace_enable, .trace_async_sel, .trace_width,
    .trace_async_data, .sync_trace_clock, .sync_trace_bit_zero, .sync_trace_bit_one, .timer_one_ch2_out_en,
    .timer_one_channel_two, .ref_output_enable, .swd_dio_out, .swd_dio_oe, .gpio_out, .gpio_oe, .pin_in,
    .other_pin_in, .interrupt_c_pin_select, .interrupt_d_pin_select, .pin_out, .pin_oe, .pin_pullup,
    .pin_analog, .vref_drive, .debug_mode_swd, .debug_test_data_in, .debug_test_mode_select, .swd_dio_in,
    .debug_test_reset_n, .ext_interrupt_a, .ext_interrupt_c, .ext_interrupt_d, .timer_one_channel_two_in,
    .timer_one_ext_clock, .timer_two_clock_mask, .gpio_in);

  dtpfs_board board (.clk, .pin_out, .pin_oe, .pin_pullup, .dbg_oe, .dbg_val, .pin_in);

  ////////////////////////////////////////////////////////////
  // fixed waits only: every output is registered; pads follow a mode switch request two edges later
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [5:0] got, input logic [5:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    tick(3);
    chk_bit(debug_test_reset_n, 1'h1, "debug_test_reset in reset");
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    tick(3);
    chk_bit(debug_mode_swd, 1'h0, "mode after reset");
    chk_vec(pin_pullup, 6'h13, "debug pull-ups");
    chk_bit(debug_test_data_in, 1'h1, "pulled data in");
  endtask

  task automatic t_jtag();
    @(posedge clk);
    gpio_oe <= 6'h13;
    dbg_oe <= 6'h13;
    dbg_val <= 6'h02;
    tick(3);
    chk_vec(pin_oe, 6'h00, "gpio held off");
    chk_bit(debug_test_mode_select, 1'h1, "mode select in");
    chk_bit(debug_test_reset_n, 1'h0, "debug_test_reset taken");
    @(posedge clk);
    port_c_low_config <= 16'h1119;
    trace_enable <= 1'h1;
    dbg_val <= 6'h00;
    for (int w = 0; w < 4; w++)
    begin
      @(posedge clk);
      trace_width <= dtpfs_trace_width_e'(w);
      tick(3);
      chk_bit(pin_oe[4], w > 1, "trace one oe");
      chk_bit(debug_test_reset_n, w > 1, "debug_test_reset gated");
    end
    @(posedge clk);
    sync_trace_bit_one <= 1'h1;
    tick(3);
    chk_bit(pin_out[4], 1'h1, "trace one value");
    @(posedge clk);
    trace_enable <= 1'h0;
    tick(3);
    chk_bit(pin_oe[4], 1'h0, "trace one off");
    @(posedge clk);
    port_c_low_config <= 16'h1111;
    trace_width <= DTPFS_TW_NONE;
    dbg_oe <= 6'h00;
  endtask

  task automatic t_bit5();
    @(posedge clk);
    debug_pin_config <= 8'h20;
    gpio_out <= 6'h02;
    tick(3);
    chk_vec(pin_oe, 6'h13, "released pads");
    chk_vec(pin_out & 6'h13, 6'h02, "released values");
    chk_vec(pin_pullup, 6'h00, "no pull-ups");
    chk_bit(debug_test_reset_n, 1'h1, "debug_test_reset ignored");
    @(posedge clk);
    debug_pin_config <= 8'h00;
    gpio_oe <= 6'h00;
  endtask

  task automatic t_swd();
    @(posedge clk);
    swd_switch_req <= 1'h1;
    @(posedge clk);
    swd_switch_req <= 1'h0;
    swd_dio_oe <= 1'h1;
    gpio_oe <= 6'h11;
    gpio_out <= 6'h01;
    #1;
    chk_bit(debug_mode_swd, 1'h1, "swd entered");
    tick(3);
    chk_vec(pin_oe, 6'h13, "swd pads");
    chk_vec(pin_out, 6'h01, "swd values");
    chk_vec(pin_pullup, 6'h02, "swd pull-up");
    @(posedge clk);
    swd_dio_oe <= 1'h0;
    gpio_oe <= 6'h00;
    dbg_oe <= 6'h12;
    dbg_val <= 6'h02;
    tick(3);
    chk_bit(swd_dio_in, 1'h1, "swd data in");
    chk_bit(debug_test_reset_n, 1'h1, "debug_test_reset in swd");
    @(posedge clk);
    jtag_switch_req <= 1'h1;
    @(posedge clk);
    jtag_switch_req <= 1'h0;
    swd_switch_req <= 1'h1;
    #1;
    chk_bit(debug_mode_swd, 1'h0, "back to jtag");
    @(posedge clk);
    system_reset_n <= 1'h0;
    // the request was taken on this very edge; system reset only acts on the next one
    #1;
    chk_bit(debug_mode_swd, 1'h1, "swd again");
    tick(1);
    chk_bit(debug_mode_swd, 1'h0, "system reset");
    @(posedge clk);
    system_reset_n <= 1'h1;
    swd_switch_req <= 1'h0;
    dbg_oe <= 6'h00;
  endtask

  task automatic t_trace();
    @(posedge clk);
    port_c_low_config <= 16'h1191;
    port_b_low_config <= 16'h1119;
    trace_enable <= 1'h1;
    trace_async_sel <= 1'h1;
    trace_async_data <= 1'h1;
    sync_trace_clock <= 1'h1;
    tick(3);
    chk_vec(pin_oe & 6'h0C, 6'h0C, "async and clock oe");
    chk_vec(pin_out & 6'h0C, 6'h0C, "async and clock out");
    @(posedge clk);
    trace_async_sel <= 1'h0;
    trace_async_data <= 1'h0;
    sync_trace_bit_zero <= 1'h1;
    for (int w = 0; w < 4; w++)
    begin
      @(posedge clk);
      trace_width <= dtpfs_trace_width_e'(w);
      tick(3);
      chk_bit(pin_oe[3], w > 0, "trace zero oe");
      chk_bit(pin_out[3] | ~pin_oe[3], 1'h1, "trace zero out");
    end
    @(posedge clk);
    trace_enable <= 1'h0;
    tick(3);
    chk_vec(pin_oe & 6'h0C, 6'h00, "trace disabled");
    @(posedge clk);
    port_c_low_config <= 16'h1101;
    port_b_low_config <= 16'h1110;
    port_b_high_config <= 16'h0111;
    gpio_oe <= 6'h2C;
    tick(3);
    chk_vec(pin_analog, 6'h2C, "analog pins");
    chk_vec(pin_oe, 6'h00, "analog no drive");
    chk_bit(vref_drive, 1'h0, "vref input");
    @(posedge clk);
    ref_output_enable <= 1'h1;
    port_c_low_config <= 16'h1111;
    port_b_high_config <= 16'h1111;
    tick(3);
    chk_bit(vref_drive, 1'h1, "vref out");
    chk_vec(pin_oe, 6'h28, "gpio only");
    @(posedge clk);
    ref_output_enable <= 1'h0;
    port_b_low_config <= 16'h1111;
    gpio_oe <= 6'h00;
  endtask

  task automatic t_timer();
    @(posedge clk);
    port_b_high_config <= 16'h9111;
    timer_one_ch2_out_en <= 1'h1;
    timer_one_channel_two <= 1'h1;
    tick(3);
    chk_bit(pin_oe[5] & pin_out[5], 1'h1, "timer out");
    @(posedge clk);
    timer_one_ch2_out_en <= 1'h0;
    tick(3);
    chk_bit(pin_oe[5], 1'h0, "timer off");
    @(posedge clk);
    port_b_high_config <= 16'hD111;
    timer_one_ch2_out_en <= 1'h1;
    tick(3);
    chk_bit(pin_oe[5], 1'h0, "open-drain high");
    @(posedge clk);
    timer_one_channel_two <= 1'h0;
    tick(3);
    chk_vec({pin_oe[5], pin_out[5], 4'h0}, 6'h20, "open-drain low");
    @(posedge clk);
    port_b_high_config <= 16'h1111;
    dbg_oe <= 6'h34;
    dbg_val <= 6'h20;
    tick(3);
    chk_bit(ext_interrupt_c, 1'h1, "default c");
    chk_bit(timer_one_channel_two_in, 1'h1, "timer in");
    chk_bit(ext_interrupt_a, 1'h0, "a low");
    @(posedge clk);
    dbg_val <= 6'h14;
    interrupt_d_pin_select <= 5'h18;
    tick(3);
    chk_bit(ext_interrupt_a, 1'h1, "a high");
    chk_bit(timer_one_ext_clock & timer_two_clock_mask, 1'h1, "shared clock");
    chk_bit(ext_interrupt_d, 1'h1, "default d");
    // slot 3 floats here, so it is masked out
    chk_vec(gpio_in & 6'h37, 6'h17, "gpio in");
    @(posedge clk);
    interrupt_c_pin_select <= 5'h07;
    interrupt_d_pin_select <= 5'h17;
    other_pin_in <= 24'h800080;
    // default pins low, so only a routed source can read high
    dbg_val <= 6'h00;
    tick(3);
    chk_vec({ext_interrupt_c, ext_interrupt_d, 4'h0}, 6'h30, "routed c d");
    @(posedge clk);
    dbg_oe <= 6'h00;
  endtask

  initial
  begin
    t_reset();
    t_jtag();
    t_bit5();
    t_swd();
    t_trace();
    t_timer();
    print_verdict();
  end
endmodule // dtpfs_pin_mux_bench
